//--- core/serial_report_cfg.svh
// Offsets, reset values, limits and timing counts of the serial report transmitter
`ifndef SERIAL_REPORT_CFG_SVH
`define SERIAL_REPORT_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_STATION 8'h00
`define OFS_SPEED 8'h04
`define OFS_FRAME 8'h08
`define OFS_INIT_SPEED 8'h0c
`define OFS_LAYOUT 8'h10
`define OFS_CYCLE 8'h14
`define OFS_SOURCE 8'h18
`define OFS_FIELDBUS 8'h1c
`define OFS_COMMAND 8'h20
`define OFS_STATUS 8'h24

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define STATION_MIN 8'h0b
`define STATION_MAX 8'h63
`define USB_STATION 8'h0b
`define RST_STATION 8'h0b
`define SPEED_115200 2'h3
`define SPEED_9600 2'h0
`define FRAME_8N1 4'h8
`define FRAME_MAX 4'h9
`define CYCLE_MAX 16'hea60
`define SOURCE_COUNT 20
`define SOURCE_RSVD_A 5'h0b
`define SOURCE_RSVD_B 5'h0c
`define FIELDBUS_MAX 8'hf7
`define CMD_PRINT_BIT 0

// ----------------------------------------------------------------------
// Characters and timing
// ----------------------------------------------------------------------
`define CHAR_LF 8'h0a
`define CHAR_CR 8'h0d
`define CHAR_PLUS 8'h2b
`define CHAR_MINUS 8'h2d
`define CHAR_ZERO 8'h30
`define CLK_HZ 100000000
`define SUSPEND_S 20
`define DIV_38400 (`CLK_HZ / 38400)
`define DIV_115200 (`CLK_HZ / 115200)

`endif

//--- core/serial_report_pkg.sv
// Types shared by the serial report transmitter
package serial_report_pkg;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PARITY,
    TX_STOP
  } tx_state_t;

  typedef struct packed {
    logic eight_bits;
    logic parity_on;
    logic parity_odd;
    logic two_stops;
  } frame_t;

endpackage

//--- core/serial_report_tx.sv
// Serial report transmitter: settings, cyclic scheduling and character framing
//
// Behaviour
// - Station address 11..99 recognises own requests
// - Addresses containing zero are broadcast, refused
// - USB link forces station address 11
// - Speed codes 0..3 map 9600..115200 baud; register accepts code 3 only
// - USB link forces 115200 baud
// - Frame codes 0..9 select bits, parity, stops
// - USB and variant use 8-none-1 only
// - Start-up select 0: initialise at 9600
// - Start-up select 1: initialise at configured speed
// - USB initialisation always at 115200
// - Layout 0: address, sign, digits, LF, CR
// - Layout 1: sign, digits, LF, CR
// - Cyclic report every configured seconds, max 60000
// - Own-station or broadcast request suspends cycling for 20 s
// - Cycle zero: reports only on request/print
// - Source codes 0..19, 11 and 12 reserved
// - Fieldbus 0 keeps ASCII; Modbus unavailable
// - Modbus never selectable over USB
`include "serial_report_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module serial_report_tx
  import serial_report_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = `CLK_HZ,
  parameter int unsigned DIV_9600 = `CLK_HZ / 9600,
  parameter int unsigned DIV_19200 = `CLK_HZ / 19200
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link context
  input wire logic usb_link,
  input wire logic init_active,
  // Received requests
  input wire logic req_valid,
  input wire logic [7:0] req_addr,
  // Measured values: sign (1 = negative) and seven BCD digits each
  input wire logic [19:0] val_neg,
  input wire logic [19:0][27:0] val_bcd,
  // Serial line
  output logic tx_line,
  output logic tx_busy
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic station_ok(input logic [7:0] a);
    station_ok = (a >= `STATION_MIN) && (a <= `STATION_MAX) && (a % 8'd10 != 8'd0);
  endfunction

  function automatic logic is_broadcast(input logic [7:0] a);
    is_broadcast = (a < 8'd10) || (a % 8'd10 == 8'd0);
  endfunction

  function automatic logic [13:0] speed_div(input logic [1:0] code);
    case (code)
      2'h0: speed_div = 14'(DIV_9600);
      2'h1: speed_div = 14'(DIV_19200);
      2'h2: speed_div = 14'(`DIV_38400);
      default: speed_div = 14'(`DIV_115200);
    endcase
  endfunction

  function automatic frame_t frame_decode(input logic [3:0] code);
    frame_t f;
    f.eight_bits = (code >= 4'h6);
    f.parity_on = (code < 4'h4) || (code == 4'h6) || (code == 4'h7);
    f.parity_odd = (code == 4'h2) || (code == 4'h3) || (code == 4'h7);
    f.two_stops = (code < 4'h6) ? code[0] : (code == 4'h9);
    frame_decode = f;
  endfunction

  function automatic logic [7:0] report_char(input logic [3:0] idx, input logic layout,
                                             input logic [7:0] addr, input logic neg,
                                             input logic [27:0] bcd);
    logic [3:0] pos;
    logic [27:0] shifted;
    pos = layout ? idx + 4'd2 : idx;
    shifted = bcd >> (5'd4 * (5'd9 - 5'(pos)));
    case (pos)
      4'd0: report_char = `CHAR_ZERO + addr / 8'd10;
      4'd1: report_char = `CHAR_ZERO + addr % 8'd10;
      4'd2: report_char = neg ? `CHAR_MINUS : `CHAR_PLUS;
      4'd10: report_char = `CHAR_LF;
      4'd11: report_char = `CHAR_CR;
      default: report_char = `CHAR_ZERO + {4'h0, shifted[3:0]};
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------------
  logic [7:0] station_ff, nxt_station;
  logic [1:0] speed_ff, nxt_speed;
  logic [3:0] frame_ff, nxt_frame;
  logic init_sel_ff, nxt_init_sel;
  logic layout_ff, nxt_layout;
  logic [15:0] cycle_ff, nxt_cycle;
  logic [4:0] source_ff, nxt_source;
  logic [7:0] fieldbus_ff, nxt_fieldbus;
  logic [31:0] rdata_ff, nxt_rdata;
  logic print_cmd;
  logic [4:0] susp_ff, nxt_susp;

  always_comb begin
    nxt_station = station_ff;
    nxt_speed = speed_ff;
    nxt_frame = frame_ff;
    nxt_init_sel = init_sel_ff;
    nxt_layout = layout_ff;
    nxt_cycle = cycle_ff;
    nxt_source = source_ff;
    nxt_fieldbus = fieldbus_ff;
    print_cmd = 1'b0;
    nxt_rdata = 32'h0;
    if (reg_wr) begin
      case (reg_addr)
        `OFS_STATION: if (station_ok(reg_wdata[7:0]) && reg_wdata[31:8] == 24'h0) begin
          nxt_station = reg_wdata[7:0];
        end
        `OFS_SPEED: if (reg_wdata == {30'h0, `SPEED_115200}) begin
          nxt_speed = reg_wdata[1:0];
        end
        `OFS_FRAME: if (reg_wdata == {28'h0, `FRAME_8N1}) begin
          nxt_frame = reg_wdata[3:0];
        end
        `OFS_INIT_SPEED: nxt_init_sel = reg_wdata[0];
        `OFS_LAYOUT: nxt_layout = reg_wdata[0];
        `OFS_CYCLE: if (reg_wdata <= {16'h0, `CYCLE_MAX}) begin
          nxt_cycle = reg_wdata[15:0];
        end
        `OFS_SOURCE: if (reg_wdata < 32'(`SOURCE_COUNT) && reg_wdata[4:0] != `SOURCE_RSVD_A
                         && reg_wdata[4:0] != `SOURCE_RSVD_B) begin
          nxt_source = reg_wdata[4:0];
        end
        `OFS_FIELDBUS: if (reg_wdata == 32'h0) begin
          nxt_fieldbus = 8'h0;
        end
        `OFS_COMMAND: print_cmd = reg_wdata[`CMD_PRINT_BIT];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `OFS_STATION: nxt_rdata = {24'h0, station_ff};
        `OFS_SPEED: nxt_rdata = {30'h0, speed_ff};
        `OFS_FRAME: nxt_rdata = {28'h0, frame_ff};
        `OFS_INIT_SPEED: nxt_rdata = {31'h0, init_sel_ff};
        `OFS_LAYOUT: nxt_rdata = {31'h0, layout_ff};
        `OFS_CYCLE: nxt_rdata = {16'h0, cycle_ff};
        `OFS_SOURCE: nxt_rdata = {27'h0, source_ff};
        `OFS_FIELDBUS: nxt_rdata = {24'h0, fieldbus_ff};
        `OFS_STATUS: nxt_rdata = {24'h0, susp_ff, usb_link, susp_ff != 5'h0, tx_busy};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      station_ff <= `RST_STATION;
      speed_ff <= `SPEED_115200;
      frame_ff <= `FRAME_8N1;
      init_sel_ff <= 1'b0;
      layout_ff <= 1'b0;
      cycle_ff <= 16'h0;
      source_ff <= 5'h0;
      fieldbus_ff <= 8'h0;
      rdata_ff <= 32'h0;
    end else begin
      station_ff <= nxt_station;
      speed_ff <= nxt_speed;
      frame_ff <= nxt_frame;
      init_sel_ff <= nxt_init_sel;
      layout_ff <= nxt_layout;
      cycle_ff <= nxt_cycle;
      source_ff <= nxt_source;
      fieldbus_ff <= nxt_fieldbus;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------------
  // Effective link settings
  // ----------------------------------------------------------------------
  logic [7:0] eff_station;
  logic [1:0] eff_speed;
  logic [3:0] eff_frame;

  always_comb begin
    eff_station = usb_link ? `USB_STATION : station_ff;
    if (usb_link) begin
      eff_speed = `SPEED_115200;
    end else if (init_active && !init_sel_ff) begin
      eff_speed = `SPEED_9600;
    end else begin
      eff_speed = speed_ff;
    end
    eff_frame = usb_link ? `FRAME_8N1 : frame_ff;
  end

  // ----------------------------------------------------------------------
  // Report scheduling
  // ----------------------------------------------------------------------
  logic [26:0] sec_cnt_ff, nxt_sec_cnt;
  logic [15:0] elapsed_ff, nxt_elapsed;
  logic pend_ff, nxt_pend;
  logic sec_tick, req_hit, start_report;

  always_comb begin
    sec_tick = (sec_cnt_ff == 27'(CYC_PER_SEC - 1));
    nxt_sec_cnt = sec_tick ? 27'h0 : sec_cnt_ff + 27'h1;
    req_hit = req_valid && (req_addr == eff_station || is_broadcast(req_addr));
    nxt_susp = susp_ff;
    nxt_elapsed = elapsed_ff;
    nxt_pend = pend_ff && !start_report;
    if (sec_tick && susp_ff != 5'h0) begin
      nxt_susp = susp_ff - 5'h1;
    end
    if (cycle_ff == 16'h0 || susp_ff != 5'h0) begin
      nxt_elapsed = 16'h0;
    end else if (sec_tick) begin
      if (elapsed_ff + 16'h1 >= cycle_ff) begin
        nxt_elapsed = 16'h0;
        nxt_pend = 1'b1;
      end else begin
        nxt_elapsed = elapsed_ff + 16'h1;
      end
    end
    if (req_hit) begin
      nxt_susp = 5'(`SUSPEND_S);
      nxt_elapsed = 16'h0;
      if (req_addr == eff_station) begin
        nxt_pend = 1'b1;
      end
    end
    if (print_cmd) begin
      nxt_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_cnt_ff <= 27'h0;
      elapsed_ff <= 16'h0;
      susp_ff <= 5'h0;
      pend_ff <= 1'b0;
    end else begin
      sec_cnt_ff <= nxt_sec_cnt;
      elapsed_ff <= nxt_elapsed;
      susp_ff <= nxt_susp;
      pend_ff <= nxt_pend;
    end
  end

  // ----------------------------------------------------------------------
  // Character framing
  // ----------------------------------------------------------------------
  tx_state_t st_ff, nxt_st;
  frame_t fr_ff, nxt_fr;
  logic [13:0] div_ff, nxt_div;
  logic [13:0] bcnt_ff, nxt_bcnt;
  logic [2:0] bit_ff, nxt_bit;
  logic stop2_ff, nxt_stop2;
  logic [7:0] shift_ff, nxt_shift;
  logic par_ff, nxt_par;
  logic [3:0] idx_ff, nxt_idx;
  logic rep_ff, nxt_rep;
  logic lay_ff, nxt_lay;
  logic [7:0] rep_addr_ff, nxt_rep_addr;
  logic neg_ff, nxt_neg;
  logic [27:0] bcd_ff, nxt_bcd;
  logic line_ff, nxt_line;
  logic baud_tick;
  logic [3:0] last_idx;
  logic [7:0] cur_char;

  assign start_report = !rep_ff && pend_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_fr = fr_ff;
    nxt_div = div_ff;
    nxt_bit = bit_ff;
    nxt_stop2 = stop2_ff;
    nxt_shift = shift_ff;
    nxt_par = par_ff;
    nxt_idx = idx_ff;
    nxt_rep = rep_ff;
    nxt_lay = lay_ff;
    nxt_rep_addr = rep_addr_ff;
    nxt_neg = neg_ff;
    nxt_bcd = bcd_ff;
    nxt_line = line_ff;
    baud_tick = (bcnt_ff == 14'h0);
    nxt_bcnt = baud_tick ? div_ff - 14'h1 : bcnt_ff - 14'h1;
    last_idx = lay_ff ? 4'd9 : 4'd11;
    cur_char = report_char(idx_ff, lay_ff, rep_addr_ff, neg_ff, bcd_ff);
    if (start_report) begin
      nxt_rep = 1'b1;
      nxt_idx = 4'h0;
      nxt_lay = layout_ff;
      nxt_rep_addr = eff_station;
      nxt_neg = val_neg[source_ff];
      nxt_bcd = val_bcd[source_ff];
    end
    case (st_ff)
      TX_IDLE: begin
        nxt_line = 1'b1;
        if (rep_ff) begin
          nxt_fr = frame_decode(eff_frame);
          nxt_div = speed_div(eff_speed);
          nxt_bcnt = speed_div(eff_speed) - 14'h1;
          nxt_shift = cur_char;
          nxt_par = 1'b0;
          nxt_line = 1'b0;
          nxt_st = TX_START;
        end
      end
      TX_START: if (baud_tick) begin
        nxt_line = shift_ff[0];
        nxt_par = shift_ff[0];
        nxt_shift = {1'b0, shift_ff[7:1]};
        nxt_bit = 3'h0;
        nxt_st = TX_DATA;
      end
      TX_DATA: if (baud_tick) begin
        if (bit_ff == (fr_ff.eight_bits ? 3'h7 : 3'h6)) begin
          if (fr_ff.parity_on) begin
            nxt_line = par_ff ^ fr_ff.parity_odd;
            nxt_st = TX_PARITY;
          end else begin
            nxt_line = 1'b1;
            nxt_stop2 = fr_ff.two_stops;
            nxt_st = TX_STOP;
          end
        end else begin
          nxt_line = shift_ff[0];
          nxt_par = par_ff ^ shift_ff[0];
          nxt_shift = {1'b0, shift_ff[7:1]};
          nxt_bit = bit_ff + 3'h1;
        end
      end
      TX_PARITY: if (baud_tick) begin
        nxt_line = 1'b1;
        nxt_stop2 = fr_ff.two_stops;
        nxt_st = TX_STOP;
      end
      TX_STOP: if (baud_tick) begin
        if (stop2_ff) begin
          nxt_stop2 = 1'b0;
        end else begin
          nxt_st = TX_IDLE;
          if (idx_ff == last_idx) begin
            nxt_rep = 1'b0;
          end else begin
            nxt_idx = idx_ff + 4'h1;
          end
        end
      end
      default: nxt_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= TX_IDLE;
      fr_ff <= '0;
      div_ff <= 14'(`DIV_115200);
      bcnt_ff <= 14'h0;
      bit_ff <= 3'h0;
      stop2_ff <= 1'b0;
      shift_ff <= 8'h0;
      par_ff <= 1'b0;
      idx_ff <= 4'h0;
      rep_ff <= 1'b0;
      lay_ff <= 1'b0;
      rep_addr_ff <= 8'h0;
      neg_ff <= 1'b0;
      bcd_ff <= 28'h0;
      line_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      fr_ff <= nxt_fr;
      div_ff <= nxt_div;
      bcnt_ff <= nxt_bcnt;
      bit_ff <= nxt_bit;
      stop2_ff <= nxt_stop2;
      shift_ff <= nxt_shift;
      par_ff <= nxt_par;
      idx_ff <= nxt_idx;
      rep_ff <= nxt_rep;
      lay_ff <= nxt_lay;
      rep_addr_ff <= nxt_rep_addr;
      neg_ff <= nxt_neg;
      bcd_ff <= nxt_bcd;
      line_ff <= nxt_line;
    end
  end

  assign tx_line = line_ff;
  assign tx_busy = rep_ff;

endmodule // serial_report_tx

`default_nettype wire

//--- tb/report_host_model.sv
// Serial host model that decodes report characters from the line
`include "serial_report_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module report_host_model #(
  parameter int unsigned DIV = `DIV_115200
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial line
  input wire logic tx_line
);
  logic [7:0] rx_q[$];
  logic [7:0] data;
  int frame_errs = 0;

  // ----------------------------------------------------------------------
  // Receiver, abandoned by a reset in mid-character
  // ----------------------------------------------------------------------
  initial begin
    forever begin
      @(negedge tx_line iff rst_b === 1'b1);
      fork
        begin
          repeat (DIV / 2) @(posedge sys_clk);
          for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge sys_clk);
            data[i] = tx_line;
          end
          repeat (DIV) @(posedge sys_clk);
          if (tx_line !== 1'b1) begin
            frame_errs++;
          end
          rx_q.push_back(data);
        end
        @(negedge rst_b);
      join_any
      disable fork;
    end
  end
endmodule  // report_host_model
`default_nettype wire

//--- tb/serial_report_tx_assertions.sv
// Concurrent checks on the serial report transmitter ports
`include "serial_report_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module serial_report_tx_checker #(
  parameter int unsigned DIV_9600 = 10416
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Context and requests
  input wire logic usb_link,
  input wire logic init_active,
  input wire logic req_valid,
  input wire logic [7:0] req_addr,
  // Serial line
  input wire logic tx_line,
  input wire logic tx_busy
);
  localparam int BIT_FAST = `DIV_115200;
  logic line_ff, nxt_line, sel_ff, nxt_sel, zero_ff, nxt_zero;
  logic [15:0] run_ff, nxt_run;
  logic [7:0] quiet_ff, nxt_quiet;

  // ----------------------------------------------------------------------
  // Line run length, shadowed settings and time since last trigger
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_line = tx_line;
    nxt_run = (tx_line != line_ff) ? 16'h0 : run_ff + {15'h0, run_ff != 16'hffff};
    nxt_sel = sel_ff;
    nxt_zero = zero_ff;
    nxt_quiet = quiet_ff + {7'h0, quiet_ff != 8'hff};
    if (reg_wr && reg_addr == `OFS_INIT_SPEED) begin
      nxt_sel = reg_wdata[0];
    end
    if (reg_wr && reg_addr == `OFS_CYCLE && reg_wdata <= 32'h0000ea60) begin
      nxt_zero = (reg_wdata == 32'h0);
    end
    if (req_valid || tx_busy || (reg_wr && reg_addr == `OFS_COMMAND)) begin
      nxt_quiet = 8'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_ff <= 1'b1;
      run_ff <= 16'h0;
      sel_ff <= 1'b0;
      zero_ff <= 1'b1;
      quiet_ff <= 8'h0;
    end else begin
      line_ff <= nxt_line;
      run_ff <= nxt_run;
      sel_ff <= nxt_sel;
      zero_ff <= nxt_zero;
      quiet_ff <= nxt_quiet;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_bit_fast: assert property (tx_line && !line_ff &&
    (usb_link || !init_active || sel_ff) |-> run_ff >= 16'(BIT_FAST - 1))
    else $error("low bit shorter than the fast bit time");
  a_bit_init: assert property (tx_line && !line_ff && init_active &&
    !usb_link && !sel_ff |-> run_ff >= 16'(DIV_9600 - 1))
    else $error("start-up bit shorter than the slow bit time");
  a_idle_high: assert property (!tx_busy |-> tx_line)
    else $error("line low outside a report");
  a_station_legal: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_STATION
    |-> reg_rdata inside {[32'hb:32'h63]} && reg_rdata % 32'ha != 32'h0)
    else $error("illegal station address held");
  a_speed_fixed: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_SPEED
    |-> reg_rdata == 32'h3)
    else $error("speed code other than the fast one held");
  a_frame_fixed: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_FRAME
    |-> reg_rdata == 32'h8)
    else $error("frame code other than 8-none-1 held");
  a_bus_ascii: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_FIELDBUS
    |-> reg_rdata == 32'h0)
    else $error("fieldbus protocol selected");
  a_source_legal: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_SOURCE
    |-> reg_rdata < 32'h14 && reg_rdata != 32'hb && reg_rdata != 32'hc)
    else $error("reserved or missing source held");
  a_cycle_limit: assert property ($past(reg_rd) && $past(reg_addr) == `OFS_CYCLE
    |-> reg_rdata <= 32'h0000ea60)
    else $error("cycle time above limit held");
  a_usb_answer: assert property (req_valid && usb_link && req_addr == 8'h0b && !tx_busy
    |-> ##[1:3] tx_busy)
    else $error("request to the fixed link address not answered");
  a_cycle_off: assert property ($rose(tx_busy) && zero_ff |-> quiet_ff < 8'h4)
    else $error("report started without trigger while cycling is off");
endmodule  // serial_report_tx_checker
`default_nettype wire

bind serial_report_tx serial_report_tx_checker #(.DIV_9600(DIV_9600)) serial_report_tx_checker_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_link(usb_link), .init_active(init_active),
  .req_valid(req_valid), .req_addr(req_addr), .tx_line(tx_line), .tx_busy(tx_busy));

//--- tb/test_serial_report_tx.sv
// Self-checking bench of the serial report transmitter
`include "serial_report_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module test_serial_report_tx;
  logic sys_clk, rst_b, reg_wr, reg_rd, usb_link, init_active, req_valid, tx_line, tx_busy;
  logic [7:0] reg_addr, req_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [19:0] val_neg;
  logic [19:0][27:0] val_bcd;
  int fail_count, comparisons;
  logic [7:0] rst_a[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h40};
  logic [31:0] rst_v[10] = '{32'hb, 32'h3, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0] bad_a[12] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h14, 8'h18, 8'h18,
    8'h18, 8'h1c, 8'h1c};
  logic [31:0] bad_d[12] = '{32'ha, 32'h14, 32'h64, 32'h0, 32'h1, 32'h2, 32'hea61, 32'hb, 32'hc,
    32'h14, 32'h1, 32'hf7};
  logic [31:0] bad_k[12] = '{32'hb, 32'hb, 32'hb, 32'h3, 32'h3, 32'h3, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0};

  serial_report_tx #(.CYC_PER_SEC(1000), .DIV_9600(2000), .DIV_19200(1000)) serial_report_tx_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_link(usb_link), .init_active(init_active),
    .req_valid(req_valid), .req_addr(req_addr), .val_neg(val_neg), .val_bcd(val_bcd),
    .tx_line(tx_line), .tx_busy(tx_busy));
  report_host_model report_host_model_inst (.sys_clk(sys_clk), .rst_b(rst_b), .tx_line(tx_line));

  // ----------------------------------------------------------------------
  // Access tasks and comparison
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic req(input logic [7:0] a);
    req_addr <= a;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic do_reset(input logic usb, input logic init);
    rst_b <= 1'b0;
    usb_link <= usb;
    init_active <= init;
    repeat (6) @(posedge sys_clk);
    report_host_model_inst.rx_q.delete();
    // Slow start-up frames are not meant for the fast host receiver
    report_host_model_inst.frame_errs = 0;
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wait_busy(input int lim, input logic want);
    int n;
    n = 0;
    while (tx_busy !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(tx_busy), 32'(want));
  endtask
  task automatic get_char(input logic [7:0] want);
    int n;
    n = 0;
    while (report_host_model_inst.rx_q.size() == 0 && n < 12000) begin
      @(posedge sys_clk);
      n++;
    end
    v = 32'hffff_ffff;
    if (n < 12000) begin
      v = 32'(report_host_model_inst.rx_q.pop_front());
    end
    check(v, 32'(want));
  endtask
  task automatic start_len(input int want);
    int n;
    n = 0;
    while (tx_line === 1'b1 && n < 30000) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    // Line is looked at mid-cycle, away from the edge that launches it
    while (tx_line === 1'b0 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    check(32'(n), 32'(want));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (95000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    usb_link = 1'b0;
    init_active = 1'b0;
    req_valid = 1'b0;
    req_addr = 8'h0;
    val_neg = 20'h02000;
    val_bcd = '0;
    val_bcd[13] = 28'h7654321;
    @(posedge sys_clk);
    do_reset(1'b0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      rd(rst_a[i], v);
      check(v, rst_v[i]);
    end
    for (int i = 0; i < 12; i++) begin
      wr(bad_a[i], bad_d[i]);
      rd(bad_a[i], v);
      check(v, bad_k[i]);
    end
    for (int f = 0; f < 10; f++) begin
      wr(`OFS_FRAME, 32'(f));
      rd(`OFS_FRAME, v);
      check(v, 32'h8);
    end
    wait_busy(3000, 1'b0);
    wr(`OFS_CYCLE, 32'hea60);
    rd(`OFS_CYCLE, v);
    check(v, 32'hea60);
    wr(`OFS_STATION, 32'h19);
    wr(`OFS_SOURCE, 32'hd);
    rd(`OFS_STATION, v);
    check(v, 32'h19);
    rd(`OFS_SOURCE, v);
    check(v, 32'hd);
    req(8'h19);
    wait_busy(4, 1'b1);
    rd(`OFS_STATUS, v);
    check(v & 32'h7, 32'h3);
    get_char(8'h32);
    get_char(8'h35);
    get_char(8'h2d);
    do_reset(1'b0, 1'b0);
    wr(`OFS_SOURCE, 32'hd);
    wr(`OFS_LAYOUT, 32'h1);
    wr(`OFS_COMMAND, 32'h1);
    get_char(8'h2d);
    get_char(8'h37);
    do_reset(1'b1, 1'b1);
    wr(`OFS_STATION, 32'h19);
    wr(`OFS_FIELDBUS, 32'h1);
    rd(`OFS_FIELDBUS, v);
    check(v, 32'h0);
    rd(`OFS_STATUS, v);
    check(v & 32'h4, 32'h4);
    req(8'h0b);
    start_len(`DIV_115200);
    get_char(8'h31);
    do_reset(1'b0, 1'b1);
    wr(`OFS_COMMAND, 32'h1);
    start_len(2000);
    do_reset(1'b0, 1'b1);
    wr(`OFS_INIT_SPEED, 32'h1);
    wr(`OFS_COMMAND, 32'h1);
    start_len(`DIV_115200);
    do_reset(1'b0, 1'b0);
    wr(`OFS_CYCLE, 32'h1);
    wait_busy(2100, 1'b1);
    do_reset(1'b0, 1'b0);
    req(8'h14);
    wr(`OFS_CYCLE, 32'h1);
    wait_busy(18500, 1'b0);
    wait_busy(3000, 1'b1);
    check(32'(report_host_model_inst.frame_errs), 32'h0);
    summarize();
  end
endmodule  // test_serial_report_tx
`default_nettype wire
